// file: logic/sonet_ei_pkg.sv
package sonet_ei_pkg;
  localparam int unsigned ADDR_W   = 18;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned QUAD_CH  = 4;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned CNT_LSB  = 0;
  localparam int unsigned IRQ_W    = 3;

  localparam logic [ADDR_W-1:0] OFS_ERR_COUNT  = 18'h3000C;
  localparam logic [ADDR_W-1:0] OFS_A1_SUB     = 18'h3000D;
  localparam logic [ADDR_W-1:0] OFS_A2_SUB     = 18'h3000E;
  localparam logic [ADDR_W-1:0] OFS_B1_MASK    = 18'h3000F;
  localparam logic [ADDR_W-1:0] OFS_ALARM_A    = 18'h30010;
  localparam logic [ADDR_W-1:0] OFS_ALARM_EN   = 18'h30011;
  localparam logic [ADDR_W-1:0] OFS_ALARM_B    = 18'h30014;
  localparam logic [ADDR_W-1:0] OFS_INS_CMD    = 18'h30030;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 18'h30031;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 18'h30032;

  localparam logic [DATA_W-1:0]  RST_BYTE  = 8'h00;
  localparam logic [QUAD_CH-1:0] RST_EN    = 4'h0;
  localparam logic [CNT_W-1:0]   RST_CNT   = 4'h0;
  localparam logic [IRQ_W-1:0]   RST_IRQ   = 3'h0;

  localparam int unsigned IRQ_ALARM_A  = 0;
  localparam int unsigned IRQ_ALARM_B  = 1;
  localparam int unsigned IRQ_INS_DONE = 2;

  typedef enum logic [1:0] {
    KIND_PAYLOAD = 2'h0,
    KIND_A1      = 2'h1,
    KIND_A2      = 2'h3,
    KIND_B1      = 2'h2
  } byte_kind_t;
endpackage

// file: logic/frame_insert_counter.sv
module frame_insert_counter #(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned CNT_W  = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic [NUM_CH-1:0] i_load,
  input  wire logic [CNT_W-1:0]  i_count,
  input  wire logic [NUM_CH-1:0] i_consume,
  output logic      [NUM_CH-1:0] o_busy,
  output logic      [NUM_CH-1:0] o_done
);
  logic [CNT_W-1:0]  left_q [NUM_CH];
  logic [NUM_CH-1:0] done_q;

  // a load in the same cycle as a consume restarts the burst
  always_ff @(posedge i_clk_sys)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!i_rstn)
        left_q[c] <= '0;
      else if (i_load[c])
        left_q[c] <= i_count;
      else if (i_consume[c] && left_q[c] != '0)
        left_q[c] <= left_q[c] - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!i_rstn)
        done_q[c] <= 1'b0;
      else
        done_q[c] <= i_consume[c] && !i_load[c] && left_q[c] == CNT_W'(1);
    end
  end

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
      o_busy[c] = left_q[c] != '0;
  end

  assign o_done = done_q;
endmodule

// file: logic/alarm_consolidate.sv
module alarm_consolidate #(
  parameter int unsigned QUAD_CH = 4
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  input  wire logic [2*QUAD_CH-1:0] i_raw,
  input  wire logic [QUAD_CH-1:0]   i_enable,
  output logic      [2*QUAD_CH-1:0] o_alarm,
  output logic      [2*QUAD_CH-1:0] o_rise
);
  logic [2*QUAD_CH-1:0] alarm_q;
  logic [2*QUAD_CH-1:0] rise_q;
  wire  [2*QUAD_CH-1:0] alarm_d;

  // one enable bit covers the same lane of both quads
  assign alarm_d = i_raw & {i_enable, i_enable};

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      alarm_q <= '0;
      rise_q  <= '0;
    end
    else
    begin
      alarm_q <= alarm_d;
      rise_q  <= alarm_d & ~alarm_q;
    end
  end

  assign o_alarm = alarm_q;
  assign o_rise  = rise_q;
endmodule

// file: logic/sonet_error_insert_alarm_regs.sv
// Summary of operation
// RL1 - active insertion replaces framing byte one
// RL2 - active insertion replaces framing byte two
// RL3 - mask ones invert outgoing parity byte bits
// RL4 - alarm bit 0 reports lane zero
// RL5 - alarm bit 1 reports lane one
// RL6 - alarm bit 2 reports lane two
// RL7 - alarm bit 3 lane three, rest zero
// RL8 - enable bit gates same lane, both quads
// RL9 - insert command corrupts count frames
// RL10 - second quad alarms in own register
// RL11 - insertion registers reset to zero
module sonet_error_insert_alarm_regs #(
  parameter int unsigned NUM_CH  = sonet_ei_pkg::NUM_CH,
  parameter int unsigned QUAD_CH = sonet_ei_pkg::QUAD_CH
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rstn,
  input  wire logic [17:0]              i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [7:0]               o_rdata,
  input  wire logic                     i_tx_valid,
  input  wire logic [2:0]               i_tx_ch,
  input  wire sonet_ei_pkg::byte_kind_t i_tx_kind,
  input  wire logic [7:0]               i_tx_byte,
  output logic                          o_tx_valid,
  output logic      [2:0]               o_tx_ch,
  output logic      [7:0]               o_tx_byte,
  input  wire logic [7:0]               i_alarm_raw,
  output logic                          o_irq
);
  function automatic logic hit(input logic [17:0] a, input logic [17:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [NUM_CH-1:0] onehot(input logic [2:0] ch);
    onehot = NUM_CH'(1) << ch;
  endfunction

  logic [7:0]         a1_q;
  logic [7:0]         a2_q;
  logic [7:0]         b1_mask_q;
  logic [3:0]         err_cnt_q;
  logic [3:0]         alm_en_q;
  logic [2:0]         irq_stat_q;
  logic [2:0]         irq_mask_q;
  logic [7:0]         rdata_q;
  logic               tx_valid_q;
  logic [2:0]         tx_ch_q;
  logic [7:0]         tx_byte_q;
  logic               irq_q;
  logic [7:0]         rdata_d;
  logic [NUM_CH-1:0]  ins_busy;
  logic [NUM_CH-1:0]  ins_done;
  logic [7:0]         alarm_vis;
  logic [7:0]         alarm_rise;

  wire sel_cnt   = hit(i_addr, sonet_ei_pkg::OFS_ERR_COUNT);
  wire sel_a1    = hit(i_addr, sonet_ei_pkg::OFS_A1_SUB);
  wire sel_a2    = hit(i_addr, sonet_ei_pkg::OFS_A2_SUB);
  wire sel_b1    = hit(i_addr, sonet_ei_pkg::OFS_B1_MASK);
  wire sel_alm_a = hit(i_addr, sonet_ei_pkg::OFS_ALARM_A);
  wire sel_en    = hit(i_addr, sonet_ei_pkg::OFS_ALARM_EN);
  wire sel_alm_b = hit(i_addr, sonet_ei_pkg::OFS_ALARM_B);
  wire sel_cmd   = hit(i_addr, sonet_ei_pkg::OFS_INS_CMD);
  wire sel_stat  = hit(i_addr, sonet_ei_pkg::OFS_IRQ_STAT);
  wire sel_mask  = hit(i_addr, sonet_ei_pkg::OFS_IRQ_MASK);

  wire wr_cnt  = i_wr && sel_cnt;
  wire wr_a1   = i_wr && sel_a1;
  wire wr_a2   = i_wr && sel_a2;
  wire wr_b1   = i_wr && sel_b1;
  wire wr_en   = i_wr && sel_en;
  wire wr_cmd  = i_wr && sel_cmd;
  wire wr_stat = i_wr && sel_stat;
  wire wr_mask = i_wr && sel_mask;

  // transmit byte classification
  wire tx_a1    = i_tx_valid && (i_tx_kind == sonet_ei_pkg::KIND_A1);
  wire tx_a2    = i_tx_valid && (i_tx_kind == sonet_ei_pkg::KIND_A2);
  wire tx_b1    = i_tx_valid && (i_tx_kind == sonet_ei_pkg::KIND_B1);
  wire ch_busy  = ins_busy[i_tx_ch];
  wire sub_a1   = tx_a1 && ch_busy;
  wire sub_a2   = tx_a2 && ch_busy;
  wire [7:0] b1_flip = i_tx_byte ^ b1_mask_q;

  // a frame counts as corrupted once its second framing byte went out
  wire [NUM_CH-1:0] ins_load    = wr_cmd ? i_wdata[NUM_CH-1:0] : '0;
  wire [NUM_CH-1:0] ins_consume = sub_a2 ? onehot(i_tx_ch) : '0;

  wire [7:0] tx_byte_d = sub_a1 ? a1_q :
                         sub_a2 ? a2_q :
                         tx_b1  ? b1_flip : i_tx_byte;

  wire [2:0] irq_event = {|ins_done, |alarm_rise[7:4], |alarm_rise[3:0]};
  wire [2:0] irq_clr   = wr_stat ? i_wdata[2:0] : 3'h0;
  // an event in the clearing cycle survives
  wire [2:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_event;
  wire [2:0] irq_mask_d = wr_mask ? i_wdata[2:0] : irq_mask_q;

  frame_insert_counter #(
    .NUM_CH (NUM_CH),
    .CNT_W  (sonet_ei_pkg::CNT_W)
  ) u_insert (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_load    (ins_load),
    .i_count   (err_cnt_q),
    .i_consume (ins_consume),
    .o_busy    (ins_busy),
    .o_done    (ins_done)
  );

  alarm_consolidate #(
    .QUAD_CH (QUAD_CH)
  ) u_alarm (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_raw     (i_alarm_raw),
    .i_enable  (alm_en_q),
    .o_alarm   (alarm_vis),
    .o_rise    (alarm_rise)
  ); // [RL8]

  // unmapped addresses read zero
  always_comb
  begin
    if (!i_rd)
      rdata_d = 8'h00;
    else if (sel_cnt)
      rdata_d = {4'h0, err_cnt_q};
    else if (sel_a1)
      rdata_d = a1_q;
    else if (sel_a2)
      rdata_d = a2_q;
    else if (sel_b1)
      rdata_d = b1_mask_q;
    else if (sel_alm_a)
      rdata_d = {4'h0, alarm_vis[3:0]}; // [RL4] [RL5] [RL6] [RL7]
    else if (sel_en)
      rdata_d = {4'h0, alm_en_q};
    else if (sel_alm_b)
      rdata_d = {4'h0, alarm_vis[7:4]}; // [RL10]
    else if (sel_cmd)
      rdata_d = 8'(ins_busy);
    else if (sel_stat)
      rdata_d = {5'h00, irq_stat_q};
    else if (sel_mask)
      rdata_d = {5'h00, irq_mask_q};
    else
      rdata_d = 8'h00;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      a1_q      <= sonet_ei_pkg::RST_BYTE; // [RL11]
      a2_q      <= sonet_ei_pkg::RST_BYTE;
      b1_mask_q <= sonet_ei_pkg::RST_BYTE;
      err_cnt_q <= sonet_ei_pkg::RST_CNT;
    end
    else
    begin
      if (wr_a1)
        a1_q <= i_wdata;
      if (wr_a2)
        a2_q <= i_wdata;
      if (wr_b1)
        b1_mask_q <= i_wdata;
      if (wr_cnt)
        err_cnt_q <= i_wdata[sonet_ei_pkg::CNT_LSB +: sonet_ei_pkg::CNT_W];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      alm_en_q   <= sonet_ei_pkg::RST_EN; // [RL8]
      irq_stat_q <= sonet_ei_pkg::RST_IRQ;
      irq_mask_q <= sonet_ei_pkg::RST_IRQ;
      irq_q      <= 1'b0;
      rdata_q    <= sonet_ei_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_en)
        alm_en_q <= i_wdata[3:0];
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_stat_d & irq_mask_d);
      rdata_q    <= rdata_d;
    end
  end

  // one stage of latency keeps all transmit outputs registered
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      tx_valid_q <= 1'b0;
      tx_ch_q    <= 3'h0;
      tx_byte_q  <= sonet_ei_pkg::RST_BYTE;
    end
    else
    begin
      tx_valid_q <= i_tx_valid;
      tx_ch_q    <= i_tx_ch;
      tx_byte_q  <= tx_byte_d; // [RL1] [RL2] [RL3] [RL9]
    end
  end

  assign o_rdata    = rdata_q;
  assign o_tx_valid = tx_valid_q;
  assign o_tx_ch    = tx_ch_q;
  assign o_tx_byte  = tx_byte_q;
  assign o_irq      = irq_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  wire rd_alm_a = i_rd && sel_alm_a;
  wire rd_alm_b = i_rd && sel_alm_b;
  wire rd_none  = i_rd && !(sel_cnt || sel_a1 || sel_a2 || sel_b1 || sel_alm_a ||
                  sel_en || sel_alm_b || sel_cmd || sel_stat || sel_mask);
  wire [3:0] alm_a_now = alarm_vis[3:0];
  wire [3:0] alm_b_now = alarm_vis[7:4];

  // separate frames-left model for lane 0, so the counter is not checked against itself
  logic [3:0] ch0_left_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      ch0_left_q <= 4'h0;
    else if (wr_cmd && i_wdata[0])
      ch0_left_q <= err_cnt_q;
    else if (sub_a2 && i_tx_ch == 3'h0 && ch0_left_q != 4'h0)
      ch0_left_q <= ch0_left_q - 4'h1;
  end

  sequence s_a1_slot;
    sub_a1;
  endsequence

  sequence s_a2_slot;
    sub_a2;
  endsequence

  property p_a1_sub;
    s_a1_slot |=> o_tx_valid && o_tx_byte == $past(a1_q);
  endproperty
  a_a1_sub: assert property (p_a1_sub) // [RL1]
    else $error("framing byte one not substituted");

  property p_a2_sub;
    s_a2_slot |=> o_tx_valid && o_tx_byte == $past(a2_q);
  endproperty
  a_a2_sub: assert property (p_a2_sub) // [RL2]
    else $error("framing byte two not substituted");

  property p_b1_flip;
    tx_b1 |=> o_tx_byte == ($past(i_tx_byte) ^ $past(b1_mask_q)) && o_tx_ch == $past(i_tx_ch);
  endproperty
  a_b1_flip: assert property (p_b1_flip) // [RL3]
    else $error("parity byte not inverted by mask");

  property p_a1_idle;
    tx_a1 && !ch_busy |=> o_tx_byte == $past(i_tx_byte);
  endproperty
  a_a1_idle: assert property (p_a1_idle) // [RL1] [RL9]
    else $error("framing byte changed while idle");

  property p_alarm_a_read;
    rd_alm_a |=> o_rdata == {4'h0, $past(alm_a_now)};
  endproperty
  a_alarm_a_read: assert property (p_alarm_a_read) // [RL4] [RL5] [RL6] [RL7]
    else $error("first quad alarm read wrong");

  property p_alarm_b_read;
    rd_alm_b |=> o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(alm_b_now);
  endproperty
  a_alarm_b_read: assert property (p_alarm_b_read) // [RL10]
    else $error("second quad alarm read wrong");

  property p_enable_gate;
    !alm_en_q[0] ##1 !alm_en_q[0] |-> !alarm_vis[0] && !alarm_vis[4];
  endproperty
  a_enable_gate: assert property (p_enable_gate) // [RL8]
    else $error("disabled lane pair shows alarm");

  property p_enable_pass;
    alm_en_q[1] && i_alarm_raw[5] |=> alarm_vis[5];
  endproperty
  a_enable_pass: assert property (p_enable_pass) // [RL8]
    else $error("enabled lane alarm not reported");

  property p_busy_from_load;
    $rose(ins_busy[0]) |-> $past(wr_cmd) && $past(i_wdata[0]);
  endproperty
  a_busy_from_load: assert property (p_busy_from_load) // [RL9]
    else $error("insertion started without command");

  property p_single_frame;
    s_a2_slot ##0 (i_tx_ch == 3'h0 && ch0_left_q == 4'h1 && !wr_cmd)
      |=> !ins_busy[0] && ins_done[0];
  endproperty
  a_single_frame: assert property (p_single_frame) // [RL9]
    else $error("single frame burst did not end");

  property p_reset_clear;
    $rose(i_rstn) |-> a1_q == 8'h00 && a2_q == 8'h00 && b1_mask_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RL11]
    else $error("insertion registers not cleared by reset");

  property p_unmapped;
    rd_none |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_sticky_set_wins;
    irq_event[2] |=> irq_stat_q[2];
  endproperty
  a_sticky_set_wins: assert property (p_sticky_set_wins)
    else $error("event lost against clear");

  property p_busy_track;
    ins_busy[0] == (ch0_left_q != 4'h0);
  endproperty
  a_busy_track: assert property (p_busy_track) // [RL9]
    else $error("lane zero busy disagrees with frames left");

  property p_a2_idle;
    tx_a2 && !ch_busy |=> o_tx_byte == $past(i_tx_byte);
  endproperty
  a_a2_idle: assert property (p_a2_idle) // [RL2] [RL9]
    else $error("framing byte two changed while idle");

  property p_payload_pass;
    i_tx_valid && i_tx_kind == sonet_ei_pkg::KIND_PAYLOAD
      |=> o_tx_valid && o_tx_byte == $past(i_tx_byte);
  endproperty
  a_payload_pass: assert property (p_payload_pass)
    else $error("payload byte altered");

  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  property p_sticky_clear;
    wr_stat && i_wdata[2] && !irq_event[2] |=> !irq_stat_q[2];
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("status bit not cleared by write");

  property p_irq_level;
    o_irq == |(irq_stat_q & irq_mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with status");
endmodule

// file: test/frame_source.sv
module frame_source (
  input  wire logic               i_clk_sys,
  input  wire logic               i_start,
  input  wire logic [2:0]         i_ch,
  output logic                    o_valid,
  output logic      [2:0]         o_ch,
  output sonet_ei_pkg::byte_kind_t o_kind,
  output logic      [7:0]         o_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step_q;
  initial
  begin
    step_q = 3'h0;
    o_valid = 1'b0;
    o_ch = 3'h0;
    o_kind = sonet_ei_pkg::KIND_PAYLOAD;
    o_byte = 8'h00;
  end
  // one frame: A1, A2, B1, payload; idle lines keep moving so stale data cannot match
  always @(posedge i_clk_sys)
  begin
    step_q <= (step_q == 3'h0) ? {2'h0, i_start} : ((step_q == 3'h4) ? 3'h0 : step_q + 3'h1);
    o_valid <= (step_q != 3'h0 || i_start) && step_q != 3'h4;
    if (step_q == 3'h0 && i_start)
      o_ch <= i_ch;
    else if (step_q == 3'h4 || (step_q == 3'h0 && !i_start))
      o_ch <= o_ch + 3'h1;
    case (step_q)
      3'h0: o_kind <= sonet_ei_pkg::KIND_A1;
      3'h1: o_kind <= sonet_ei_pkg::KIND_A2;
      3'h2: o_kind <= sonet_ei_pkg::KIND_B1;
      default: o_kind <= sonet_ei_pkg::KIND_PAYLOAD;
    endcase
    case (step_q)
      3'h0: o_byte <= i_start ? 8'hF6 : ~o_byte;
      3'h1: o_byte <= 8'h28;
      3'h2: o_byte <= 8'h5A;
      3'h3: o_byte <= 8'h3C;
      default: o_byte <= ~o_byte;
    endcase
  end
endmodule

// file: test/test_sonet_error_insert_alarm_regs.sv
module test_sonet_error_insert_alarm_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     i_clk_sys, i_rstn, i_wr, i_rd, o_irq;
  logic                     start, tx_valid, o_tx_valid;
  logic [17:0]              i_addr;
  logic [7:0]               i_wdata, o_rdata, tx_byte, o_tx_byte, i_alarm_raw;
  logic [2:0]               src_ch, tx_ch, o_tx_ch;
  sonet_ei_pkg::byte_kind_t tx_kind;
  logic [10:0]              outq[$];
  logic [17:0]              regs[8];
  int                       mismatches, num_checks;

  sonet_error_insert_alarm_regs u_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_valid(tx_valid), .i_tx_ch(tx_ch), .i_tx_kind(tx_kind), .i_tx_byte(tx_byte),
    .o_tx_valid(o_tx_valid), .o_tx_ch(o_tx_ch), .o_tx_byte(o_tx_byte),
    .i_alarm_raw(i_alarm_raw), .o_irq(o_irq));
  frame_source u_src (.i_clk_sys(i_clk_sys), .i_start(start), .i_ch(src_ch),
    .o_valid(tx_valid), .o_ch(tx_ch), .o_kind(tx_kind), .o_byte(tx_byte));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
    if (o_tx_valid === 1'b1)
      outq.push_back({o_tx_ch, o_tx_byte});

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [17:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    chk({3'h0, o_rdata}, {3'h0, exp});
  endtask

  task automatic frame(input logic [2:0] ch, input logic [7:0] a1, a2, b1);
    @(posedge i_clk_sys);
    start <= 1'b1;
    src_ch <= ch;
    @(posedge i_clk_sys);
    start <= 1'b0;
    repeat (7) @(posedge i_clk_sys);
    chk(11'(outq.size()), 11'h004);
    chk(outq.pop_front(), {ch, a1});
    chk(outq.pop_front(), {ch, a2});
    chk(outq.pop_front(), {ch, b1});
    chk(outq.pop_front(), {ch, 8'h3C});
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge i_clk_sys);
    mismatches++;
    close_out();
  end

  initial
  begin
    {i_rstn, i_wr, i_rd, start} = 4'h0;
    {i_addr, i_wdata, src_ch, i_alarm_raw} = '0;
    regs = '{18'h3000C, 18'h3000D, 18'h3000E, 18'h3000F, 18'h30010, 18'h30011,
             18'h30014, 18'h30031};
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    frame(3'h2, 8'hF6, 8'h28, 8'h5A);
    wr(18'h3000D, 8'h11);
    wr(18'h3000E, 8'h22);
    wr(18'h3000F, 8'h81);
    wr(18'h30011, 8'hFF);
    wr(18'h30010, 8'hFF);
    wr(18'h30015, 8'hFF);
    rd(18'h3000D, 8'h11);
    rd(18'h3000E, 8'h22);
    rd(18'h3000F, 8'h81);
    rd(18'h30011, 8'h0F);
    rd(18'h30010, 8'h00);
    rd(18'h30015, 8'h00);
    // two-frame burst on lane 0; lane 1 framing bytes in between must pass untouched
    wr(18'h30032, 8'h04);
    wr(18'h3000C, 8'hF2);
    rd(18'h3000C, 8'h02);
    wr(18'h30030, 8'h01);
    rd(18'h30030, 8'h01);
    frame(3'h0, 8'h11, 8'h22, 8'hDB);
    frame(3'h1, 8'hF6, 8'h28, 8'hDB);
    frame(3'h0, 8'h11, 8'h22, 8'hDB);
    frame(3'h0, 8'hF6, 8'h28, 8'hDB);
    rd(18'h30030, 8'h00);
    rd(18'h30031, 8'h04);
    chk({10'h0, o_irq}, 11'h001);
    wr(18'h30031, 8'h04);
    rd(18'h30031, 8'h00);
    chk({10'h0, o_irq}, 11'h000);
    // alarm interrupt: raise, mask, clear
    wr(18'h30032, 8'h01);
    i_alarm_raw <= 8'h01;
    rd(18'h30010, 8'h01);
    rd(18'h30031, 8'h01);
    chk({10'h0, o_irq}, 11'h001);
    wr(18'h30032, 8'h00);
    rd(18'h30031, 8'h01);
    chk({10'h0, o_irq}, 11'h000);
    wr(18'h30031, 8'h01);
    rd(18'h30031, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      i_alarm_raw <= 8'h01 << i;
      rd(18'h30010, 8'h01 << i);
      rd(18'h30014, 8'h00);
      i_alarm_raw <= 8'h10 << i;
      rd(18'h30014, 8'h01 << i);
      rd(18'h30010, 8'h00);
    end
    i_alarm_raw <= 8'hFF;
    wr(18'h30011, 8'h05);
    rd(18'h30010, 8'h05);
    rd(18'h30014, 8'h05);
    wr(18'h30011, 8'h00);
    rd(18'h30010, 8'h00);
    rd(18'h30014, 8'h00);
    close_out();
  end
endmodule
